// file: aes_pkg.sv
// Purpose: shared constants for the block cipher engine
// Assumes: byte 0 of a block sits in bits 7:0 of a packed vector
// Notes: GF(2^8) helpers live here because the round multiplies with xtime and the engine steps round constants
package aes_pkg;
  localparam int BLK_BYTES = 16;
  localparam logic [3:0] LAST_IDX = 4'hf;
  localparam int ROUNDS = 10;
  localparam logic [3:0] LAST_RND = 4'h9;
  localparam int OP_CYCLES = 375;
  localparam logic [8:0] OP_LAST = 9'(OP_CYCLES - 1);
  localparam logic [7:0] RCON_FIRST = 8'h01;
  localparam logic [7:0] RCON_LAST = 8'h36;
  localparam logic [7:0] POLY_LOW = 8'h1b;
  localparam logic [7:0] SBOX_EXP = 8'hfe;
  localparam logic [7:0] SBOX_AFFINE = 8'h63;
  localparam logic [7:0] INV_AFFINE = 8'h05;

  typedef enum {IDLE_PH, LOAD_PH, EXPAND_PH, ROUND_PH, WAIT_PH} phase_e;

  function automatic logic [7:0] xtime(input logic [7:0] a);
    return a[7] ? ((a << 1) ^ POLY_LOW) : (a << 1);
  endfunction

  function automatic logic [7:0] inv_xtime(input logic [7:0] b);
    return b[0] ? (((b ^ POLY_LOW) >> 1) | 8'h80) : (b >> 1);
  endfunction
endpackage

// file: round_if.sv
// Purpose: carries one cipher round between sequencer and datapath
// Assumes: single clock, purely combinational datapath
// Notes: key_fwd and key_bwd are both always valid
`timescale 1ns/1ps
interface round_if;
  logic [127:0] state_in;
  logic [127:0] key_in;
  logic [7:0] rcon;
  logic decrypt;
  logic last;
  logic [127:0] state_out;
  logic [127:0] key_fwd;
  logic [127:0] key_bwd;
  modport core (input state_in, key_in, rcon, decrypt, last,
                output state_out, key_fwd, key_bwd);
  modport ctrl (output state_in, key_in, rcon, decrypt, last,
                input state_out, key_fwd, key_bwd);
endinterface

// file: aes_round.sv
// Purpose: one combinational cipher round plus key schedule step
// Assumes: decrypt rounds walk the key schedule backwards
// Notes: substitution box computed by field inversion, no table
`timescale 1ns/1ps
module aes_round (
  round_if.core rif
);
  logic [7:0] s [16];
  logic [7:0] t [16];
  logic [7:0] m [16];
  logic [7:0] c [4];
  logic [31:0] w [4];
  logic [31:0] f [4];
  logic [31:0] b [4];
  logic [7:0] acc;

  function automatic logic [7:0] gmul(input logic [7:0] a,
                                      input logic [7:0] x);
    logic [7:0] p;
    logic [7:0] q;
    p = 8'h00;
    q = a;
    for (int i = 0; i < 8; i++) begin
      if (x[i]) begin
        p = p ^ q;
      end
      q = aes_pkg::xtime(q);
    end
    return p;
  endfunction

  function automatic logic [7:0] ginv(input logic [7:0] x);
    logic [7:0] r;
    logic [7:0] p;
    r = 8'h01;
    p = x;
    for (int i = 0; i < 8; i++) begin
      if (aes_pkg::SBOX_EXP[i]) begin
        r = gmul(r, p);
      end
      p = gmul(p, p);
    end
    return r;
  endfunction

  function automatic logic [7:0] rotl(input logic [7:0] x, input int n);
    return 8'((x << n) | (x >> (8 - n)));
  endfunction

  function automatic logic [7:0] sbox(input logic [7:0] x);
    logic [7:0] v;
    v = ginv(x);
    return v ^ rotl(v, 1) ^ rotl(v, 2) ^ rotl(v, 3) ^ rotl(v, 4)
      ^ aes_pkg::SBOX_AFFINE;
  endfunction

  function automatic logic [7:0] inv_sbox(input logic [7:0] x);
    return ginv(rotl(x, 1) ^ rotl(x, 3) ^ rotl(x, 6)
      ^ aes_pkg::INV_AFFINE);
  endfunction

  function automatic logic [31:0] subrot(input logic [31:0] x,
                                         input logic [7:0] rc);
    logic [31:0] y;
    for (int k = 0; k < 4; k++) begin
      y[8*k +: 8] = sbox(x[8*((k+1)%4) +: 8]);
    end
    y[7:0] = y[7:0] ^ rc;
    return y;
  endfunction

  // ***************************************
  // round datapath
  // ***************************************
  always_comb begin
    acc = 8'h00;
    for (int i = 0; i < 4; i++) begin
      w[i] = rif.key_in[32*i +: 32];
    end
    f[0] = w[0] ^ subrot(w[3], rif.rcon);
    f[1] = w[1] ^ f[0];
    f[2] = w[2] ^ f[1];
    f[3] = w[3] ^ f[2];
    b[3] = w[3] ^ w[2];
    b[2] = w[2] ^ w[1];
    b[1] = w[1] ^ w[0];
    b[0] = w[0] ^ subrot(b[3], rif.rcon);
    for (int i = 0; i < 4; i++) begin
      rif.key_fwd[32*i +: 32] = f[i];
      rif.key_bwd[32*i +: 32] = b[i];
    end
    // (R1) shift and substitute
    for (int i = 0; i < 16; i++) begin
      s[i] = rif.state_in[8*i +: 8];
    end
    for (int cl = 0; cl < 4; cl++) begin
      for (int r = 0; r < 4; r++) begin
        if (rif.decrypt) begin
          t[4*cl+r] = inv_sbox(s[4*((cl-r+4)%4)+r])
            ^ rif.key_bwd[8*(4*cl+r) +: 8];
        end else begin
          t[4*cl+r] = sbox(s[4*((cl+r)%4)+r]);
        end
      end
    end
    if (rif.decrypt) begin
      c = '{8'h0e, 8'h0b, 8'h0d, 8'h09};
    end else begin
      c = '{8'h02, 8'h03, 8'h01, 8'h01};
    end
    for (int cl = 0; cl < 4; cl++) begin
      for (int r = 0; r < 4; r++) begin
        acc = 8'h00;
        for (int j = 0; j < 4; j++) begin
          acc = acc ^ gmul(c[(j-r+4)%4], t[4*cl+j]);
        end
        m[4*cl+r] = rif.last ? t[4*cl+r] : acc;
      end
    end
    for (int i = 0; i < 16; i++) begin
      if (rif.decrypt) begin
        rif.state_out[8*i +: 8] = m[i];
      end else begin
        rif.state_out[8*i +: 8] = m[i] ^ rif.key_fwd[8*i +: 8];
      end
    end
  end
endmodule // aes_round

// file: aes_block_cipher_engine.sv
// Purpose: 128-bit block cipher engine with byte-wide memory ports
// Assumes: strobes come from logic on ref_clk, one per access
// Notes: one round per cycle, result held back to the fixed latency
// Operation
// (R1) one 128-bit block encrypted or decrypted with a 128-bit key
// (R2) key and state fully loaded by the user before starting
// (R3) result readable only after 375 clock cycles from start
// (R4) completion raises interrupt only when interrupt is enabled
// (R5) completion pulses a transfer trigger for the DMA controller
// (R6) auto-start begins operation when last state byte is written
// (R7) xor load mode combines written byte with stored state byte
// (R8) one byte per access through auto-incrementing pointers
`timescale 1ns/1ps
module aes_block_cipher_engine (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic key_wr,
  input wire logic state_wr,
  input wire logic [7:0] wdata,
  input wire logic key_rd,
  input wire logic state_rd,
  input wire logic start,
  input wire logic decrypt,
  input wire logic auto_start_en,
  input wire logic xor_mode,
  input wire logic int_en,
  output logic [7:0] rdata,
  output logic busy,
  output logic irq,
  output logic dma_trig
);
  logic rst_meta_n_ff;
  logic rst_sync_n_ff;
  logic [7:0] key_mem_ff [16];
  logic [7:0] nxt_key_mem [16];
  logic [7:0] state_mem_ff [16];
  logic [7:0] nxt_state_mem [16];
  logic [3:0] key_ptr_ff, nxt_key_ptr;
  logic [3:0] state_ptr_ff, nxt_state_ptr;
  logic [127:0] st_ff, nxt_st;
  logic [127:0] wkey_ff, nxt_wkey;
  logic [7:0] rcon_ff, nxt_rcon;
  logic [3:0] rnd_ff, nxt_rnd;
  logic [8:0] cnt_ff, nxt_cnt;
  aes_pkg::phase_e phase_ff, nxt_phase;
  logic dec_ff, nxt_dec;
  logic [7:0] rdata_ff, nxt_rdata;
  logic busy_ff, nxt_busy;
  logic irq_ff, nxt_irq;
  logic dma_ff, nxt_dma;
  logic go;
  logic [127:0] key_vec;
  logic [127:0] state_vec;

  round_if rif ();

  aes_round u_round (
    .rif(rif)
  );

  // ***************************************
  // reset release
  // ***************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_n_ff <= 1'b0;
      rst_sync_n_ff <= 1'b0;
    end else begin
      rst_meta_n_ff <= 1'b1;
      rst_sync_n_ff <= rst_meta_n_ff;
    end
  end

  assign rif.state_in = st_ff;
  assign rif.key_in = wkey_ff;
  assign rif.rcon = rcon_ff;
  assign rif.decrypt = dec_ff;
  assign rif.last = (rnd_ff == aes_pkg::LAST_RND);

  assign rdata = rdata_ff;
  assign busy = busy_ff;
  assign irq = irq_ff;
  assign dma_trig = dma_ff;

  // ***************************************
  // next state
  // ***************************************
  always_comb begin
    nxt_key_mem = key_mem_ff;
    nxt_state_mem = state_mem_ff;
    nxt_key_ptr = key_ptr_ff;
    nxt_state_ptr = state_ptr_ff;
    nxt_st = st_ff;
    nxt_wkey = wkey_ff;
    nxt_rcon = rcon_ff;
    nxt_rnd = rnd_ff;
    nxt_cnt = cnt_ff;
    nxt_phase = phase_ff;
    nxt_dec = dec_ff;
    nxt_rdata = rdata_ff;
    nxt_busy = busy_ff;
    nxt_irq = 1'b0;
    nxt_dma = 1'b0;
    for (int i = 0; i < aes_pkg::BLK_BYTES; i++) begin
      key_vec[8*i +: 8] = key_mem_ff[i];
      state_vec[8*i +: 8] = state_mem_ff[i];
    end
    // (R6) auto start on last byte
    go = !busy_ff && (start || (auto_start_en && state_wr
      && state_ptr_ff == aes_pkg::LAST_IDX));
    if (!busy_ff) begin
      // (R8) byte access with pointer step
      if (key_wr) begin
        nxt_key_mem[key_ptr_ff] = wdata;
        nxt_key_ptr = key_ptr_ff + 4'h1;
      end else if (key_rd) begin
        nxt_rdata = key_mem_ff[key_ptr_ff];
        nxt_key_ptr = key_ptr_ff + 4'h1;
      end
      if (state_wr) begin
        // (R7) xor load mode
        nxt_state_mem[state_ptr_ff] = xor_mode
          ? (state_mem_ff[state_ptr_ff] ^ wdata) : wdata;
        nxt_state_ptr = state_ptr_ff + 4'h1;
      end else if (state_rd) begin
        nxt_rdata = state_mem_ff[state_ptr_ff];
        nxt_state_ptr = state_ptr_ff + 4'h1;
      end
    end
    if (busy_ff) begin
      nxt_cnt = cnt_ff + 9'h001;
    end
    if (go) begin
      nxt_busy = 1'b1;
      nxt_dec = decrypt;
      nxt_cnt = 9'h000;
      nxt_phase = aes_pkg::LOAD_PH;
    end
    case (phase_ff)
      aes_pkg::IDLE_PH: begin
      end
      aes_pkg::LOAD_PH: begin
        nxt_wkey = key_vec;
        nxt_rcon = aes_pkg::RCON_FIRST;
        nxt_rnd = 4'h0;
        nxt_st = state_vec ^ key_vec;
        nxt_phase = dec_ff ? aes_pkg::EXPAND_PH : aes_pkg::ROUND_PH;
      end
      aes_pkg::EXPAND_PH: begin
        nxt_wkey = rif.key_fwd;
        nxt_rcon = aes_pkg::xtime(rcon_ff);
        nxt_rnd = rnd_ff + 4'h1;
        if (rnd_ff == aes_pkg::LAST_RND) begin
          nxt_st = state_vec ^ rif.key_fwd;
          nxt_rcon = aes_pkg::RCON_LAST;
          nxt_rnd = 4'h0;
          nxt_phase = aes_pkg::ROUND_PH;
        end
      end
      aes_pkg::ROUND_PH: begin
        // (R1) one round per cycle
        nxt_st = rif.state_out;
        nxt_wkey = dec_ff ? rif.key_bwd : rif.key_fwd;
        nxt_rcon = dec_ff ? aes_pkg::inv_xtime(rcon_ff)
          : aes_pkg::xtime(rcon_ff);
        nxt_rnd = rnd_ff + 4'h1;
        if (rnd_ff == aes_pkg::LAST_RND) begin
          nxt_phase = aes_pkg::WAIT_PH;
        end
      end
      aes_pkg::WAIT_PH: begin
        // (R3) release result at fixed latency
        if (cnt_ff == aes_pkg::OP_LAST) begin
          for (int i = 0; i < aes_pkg::BLK_BYTES; i++) begin
            nxt_state_mem[i] = st_ff[8*i +: 8];
          end
          nxt_key_ptr = 4'h0;
          nxt_state_ptr = 4'h0;
          nxt_busy = 1'b0;
          nxt_phase = aes_pkg::IDLE_PH;
          // (R5) transfer trigger
          nxt_dma = 1'b1;
          // (R4) gated interrupt
          nxt_irq = int_en;
        end
      end
      default: begin
        nxt_phase = aes_pkg::IDLE_PH;
      end
    endcase
    if (go) begin
      nxt_key_ptr = 4'h0;
      nxt_state_ptr = 4'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      for (int i = 0; i < aes_pkg::BLK_BYTES; i++) begin
        key_mem_ff[i] <= 8'h00;
        state_mem_ff[i] <= 8'h00;
      end
      key_ptr_ff <= 4'h0;
      state_ptr_ff <= 4'h0;
      st_ff <= 128'h0;
      wkey_ff <= 128'h0;
      rcon_ff <= 8'h00;
      rnd_ff <= 4'h0;
      cnt_ff <= 9'h000;
      phase_ff <= aes_pkg::IDLE_PH;
      dec_ff <= 1'b0;
      rdata_ff <= 8'h00;
      busy_ff <= 1'b0;
      irq_ff <= 1'b0;
      dma_ff <= 1'b0;
    end else begin
      key_mem_ff <= nxt_key_mem;
      state_mem_ff <= nxt_state_mem;
      key_ptr_ff <= nxt_key_ptr;
      state_ptr_ff <= nxt_state_ptr;
      st_ff <= nxt_st;
      wkey_ff <= nxt_wkey;
      rcon_ff <= nxt_rcon;
      rnd_ff <= nxt_rnd;
      cnt_ff <= nxt_cnt;
      phase_ff <= nxt_phase;
      dec_ff <= nxt_dec;
      rdata_ff <= nxt_rdata;
      busy_ff <= nxt_busy;
      irq_ff <= nxt_irq;
      dma_ff <= nxt_dma;
    end
  end

  // ***************************************
  // checks
  // ***************************************
  localparam int OP_LEN = aes_pkg::OP_CYCLES;
  int blen_ff;
  always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      blen_ff <= 0;
    end else begin
      blen_ff <= busy_ff ? blen_ff + 1 : 0;
    end
  end

  cipher_rounds_a: assert property ( // (R1)
    @(posedge ref_clk) disable iff (!rst_sync_n_ff)
    $rose(busy_ff) |-> ##[11:21] (phase_ff == aes_pkg::WAIT_PH))
    else $error("rounds not finished in time");
  op_latency_a: assert property ( // (R3)
    @(posedge ref_clk) disable iff (!rst_sync_n_ff)
    $fell(busy_ff) |-> blen_ff == OP_LEN)
    else $error("operation length wrong");
  irq_gate_a: assert property ( // (R4)
    @(posedge ref_clk) disable iff (!rst_sync_n_ff)
    (irq_ff |-> dma_ff) and (dma_ff |-> irq_ff == $past(int_en)))
    else $error("interrupt not gated by enable");
  dma_done_a: assert property ( // (R5)
    @(posedge ref_clk) disable iff (!rst_sync_n_ff)
    $fell(busy_ff) |-> dma_ff ##1 !dma_ff)
    else $error("dma trigger missing");
  auto_start_a: assert property ( // (R6)
    @(posedge ref_clk) disable iff (!rst_sync_n_ff)
    (!busy_ff && auto_start_en && state_wr
      && state_ptr_ff == aes_pkg::LAST_IDX) |=> busy_ff)
    else $error("auto start missed");
  xor_load_a: assert property ( // (R7)
    @(posedge ref_clk) disable iff (!rst_sync_n_ff)
    (!busy_ff && state_wr && xor_mode && !start)
    |=> state_mem_ff[$past(state_ptr_ff)]
      == $past(state_mem_ff[state_ptr_ff] ^ wdata))
    else $error("xor load wrong");
  ptr_step_a: assert property ( // (R8)
    @(posedge ref_clk) disable iff (!rst_sync_n_ff)
    (!busy_ff && key_wr && !go) |=> key_ptr_ff
      == 4'($past(key_ptr_ff) + 4'h1))
    else $error("key pointer did not step");
endmodule // aes_block_cipher_engine

// file: aes_host_model.sv
// Purpose: processor side model loading and reading the engine memories
// Assumes: byte 0 of a block sits in bits 7:0
// Notes: strobes change just after rising edges, one byte per cycle
`timescale 1ns/1ps
module aes_host_model (
  input wire logic ref_clk,
  output logic key_wr,
  output logic state_wr,
  output logic key_rd,
  output logic state_rd,
  output logic [7:0] wdata
);
  // ************************************************************
  // byte transfers
  // ************************************************************
  initial begin
    key_wr = 1'b0;
    state_wr = 1'b0;
    key_rd = 1'b0;
    state_rd = 1'b0;
    wdata = 8'h00;
  end

  // kind 0 key write, 1 state write, 2 key read, 3 state read
  // n bytes sent, byte 0 of blk first
  task automatic xfer(input logic [1:0] kind, input int n,
                      input logic [127:0] blk);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      key_wr <= (kind == 2'h0);
      state_wr <= (kind == 2'h1);
      key_rd <= (kind == 2'h2);
      state_rd <= (kind == 2'h3);
      wdata <= blk[8*i +: 8];
    end
    @(posedge ref_clk);
    key_wr <= 1'b0;
    state_wr <= 1'b0;
    key_rd <= 1'b0;
    state_rd <= 1'b0;
    // released line must not keep the last byte
    wdata <= ~blk[8*(n-1) +: 8];
  endtask
endmodule // aes_host_model

// file: test_aes_block_cipher_engine.sv
// Purpose: self-checking bench for the block cipher engine
// Assumes: host model drives the byte strobes, bench the control levels
// Notes: expected bytes and irq values queue up, a monitor pops them
`timescale 1ns/1ps
module test_aes_block_cipher_engine;
  localparam logic [127:0] KEY = 128'h0f0e0d0c0b0a09080706050403020100;
  localparam logic [127:0] PLAIN = 128'hffeeddccbbaa99887766554433221100;
  localparam logic [127:0] CIPHER = 128'h5ac5b47080b7cdd830047b6ad8e0c469;
  localparam int LIMIT = 3000;

  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0;
  logic decrypt = 1'b0;
  logic auto_start_en = 1'b0;
  logic xor_mode = 1'b0;
  logic int_en = 1'b0;
  logic key_wr, state_wr, key_rd, state_rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic busy, irq, dma_trig;
  int errors = 0;
  int n_compared = 0;
  int n_done = 0;
  int cyc = 0;
  logic [7:0] exp_q[$];
  logic exp_irq_q[$];
  logic rd_pend = 1'b0;
  logic [8:0] bcnt = 9'h000;
  logic [31:0] seed = 32'h00000056;
  logic [127:0] rnd;

  always #25 ref_clk = ~ref_clk;

  aes_block_cipher_engine u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .key_wr(key_wr), .state_wr(state_wr),
    .wdata(wdata), .key_rd(key_rd), .state_rd(state_rd), .start(start),
    .decrypt(decrypt), .auto_start_en(auto_start_en), .xor_mode(xor_mode),
    .int_en(int_en), .rdata(rdata), .busy(busy), .irq(irq),
    .dma_trig(dma_trig)
  );

  aes_host_model u_host (
    .ref_clk(ref_clk), .key_wr(key_wr), .state_wr(state_wr),
    .key_rd(key_rd), .state_rd(state_rd), .wdata(wdata)
  );

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic end_sim;
    if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp_byte(input string name, input logic [7:0] exp,
                          input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp_evt(input string name, input logic [8:0] exp,
                         input logic [8:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic read_blk(input logic [1:0] kind, input logic [127:0] blk);
    for (int i = 0; i < 16; i++) exp_q.push_back(blk[8*i +: 8]);
    u_host.xfer(kind, 16, blk);
  endtask

  task automatic go(input logic dec, input logic ien);
    exp_irq_q.push_back(ien);
    @(posedge ref_clk);
    decrypt <= dec;
    int_en <= ien;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
  endtask

  task automatic wait_done(input int target);
    for (int i = 0; i < 400 && n_done < target; i++) @(posedge ref_clk);
    cmp_evt("done_count", 9'(target), 9'(n_done));
  endtask

  // ************************************************************
  // monitor and timeout
  // ************************************************************
  always @(posedge ref_clk) begin
    if (rd_pend) cmp_byte("rdata", exp_q.pop_front(), rdata);
    rd_pend = ((key_rd | state_rd) & ~busy) === 1'b1;
    if (busy === 1'b1) bcnt = bcnt + 9'h001;
    if (dma_trig === 1'b1) begin
      cmp_evt("busy_cycles", 9'(aes_pkg::OP_CYCLES), bcnt);
      cmp_evt("irq", {8'h00, exp_irq_q.pop_front()}, {8'h00, irq});
      bcnt = 9'h000;
      n_done++;
    end else if (nrst === 1'b1 && irq !== 1'b0) begin
      cmp_evt("irq_alone", 9'h000, {8'h00, irq});
    end
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      errors++;
      end_sim;
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    cmp_byte("rdata_reset", 8'h00, rdata);
    cmp_evt("busy_reset", 9'h000, {8'h00, busy});
    u_host.xfer(2'h0, 16, KEY);
    u_host.xfer(2'h1, 16, PLAIN);
    read_blk(2'h3, PLAIN);
    go(1'b0, 1'b1);
    // key write and second start while busy are ignored
    u_host.xfer(2'h0, 1, {120'h0, 8'haa});
    @(posedge ref_clk);
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    wait_done(1);
    read_blk(2'h3, CIPHER);
    read_blk(2'h2, KEY);
    go(1'b1, 1'b0);
    wait_done(2);
    read_blk(2'h3, PLAIN);
    for (int i = 0; i < 4; i++) begin
      seed = xorshift(seed);
      rnd[32*i +: 32] = seed;
    end
    u_host.xfer(2'h1, 16, rnd);
    exp_irq_q.push_back(1'b1);
    @(posedge ref_clk);
    auto_start_en <= 1'b1;
    xor_mode <= 1'b1;
    decrypt <= 1'b0;
    int_en <= 1'b1;
    u_host.xfer(2'h1, 16, PLAIN ^ rnd);
    wait_done(3);
    @(posedge ref_clk);
    auto_start_en <= 1'b0;
    xor_mode <= 1'b0;
    read_blk(2'h3, CIPHER);
    repeat (3) @(posedge ref_clk);
    end_sim;
  end
endmodule // test_aes_block_cipher_engine
